// ---- inc/pmc_pkg.sv ----
// package for the power mode controller: register map, field layout, timing constants
`default_nettype none
package pmc_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] PMC_MODE_OFS   = 8'h00; // global mode field
  localparam logic [7:0] PMC_SLEEP_OFS  = 8'h04; // go-sleep time
  localparam logic [7:0] PMC_PORTPD_OFS = 8'h08; // per-port power-down bits
  localparam logic [7:0] PMC_STATUS_OFS = 8'h0C; // read-only block state
  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int PMC_MODE_LSB = 3; // mode field sits at bits [4:3]
  localparam int PMC_MODE_MSB = 4;
  localparam int PMC_NPORTS   = 5; // five phy ports
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] PMC_MODE_RST  = 2'h0;
  localparam logic [7:0] PMC_SLEEP_RST = 8'h10;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int PMC_CLK_MHZ      = 100;
  localparam int PMC_PULSE_NS     = 120;                          // link pulse width
  localparam int PMC_PULSE_CYC    = (PMC_PULSE_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam int PMC_PERIOD_MS    = 1000;                         // one pulse per second
  localparam int PMC_PERIOD_CYC   = PMC_PERIOD_MS * PMC_CLK_MHZ * 1000;
  localparam int PMC_TICK_US      = 1000;                         // go-sleep unit
  localparam int PMC_TICK_CYC     = PMC_TICK_US * PMC_CLK_MHZ;
  localparam int PMC_WAKE_RST_CYC = 16;                           // internal reset length
  // ----------------------------------------------------------------
  // global power modes of the mode field
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_NORMAL   = 2'h0,
    PMC_ENERGY   = 2'h1,
    PMC_SOFT_PD  = 2'h2,
    PMC_PWR_SAVE = 2'h3
  } pmc_mode_type;
endpackage : pmc_pkg
`default_nettype wire

// ---- inc/pmc_tick_if.sv ----
// interface carrying the enable to the timer and the tick and pulse from the timer to the controller
`default_nettype none
interface pmc_tick_if;
  logic run;   // energy detect mode active
  logic tick;  // one-cycle go-sleep time base
  logic pulse; // link pulse level
  modport ctrl  (output run, input tick, input pulse);
  modport timer (input run, output tick, output pulse);
endinterface : pmc_tick_if
`default_nettype wire

// ---- verilog/pmc_pulse_timer.sv ----
// timer: go-sleep time base and the one-per-second link pulse
`default_nettype none
module pmc_pulse_timer
  import pmc_pkg::*;
#(
  parameter int PERIOD_CYC = PMC_PERIOD_CYC,
  parameter int TICK_CYC   = PMC_TICK_CYC
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // controller side
  pmc_tick_if.timer tif
);
  // elaboration check: the pulse must end inside its period and the tick needs a count
  if (PERIOD_CYC <= PMC_PULSE_CYC || TICK_CYC < 1) begin : g_bad_counts
    $error("pmc timer: bad counts");
  end
  logic [31:0] per_q; // position in the pulse period
  logic [31:0] tck_q; // position in the tick period
  // ----------------------------------------------------------------
  // counters, held at zero outside energy detect mode
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n || !tif.run) begin
      per_q     <= 32'h0000_0000;
      tif.pulse <= 1'b0;
    end else begin
      per_q     <= (per_q == 32'(PERIOD_CYC - 1)) ? 32'h0000_0000 : per_q + 32'h0000_0001;
      tif.pulse <= (per_q < 32'(PMC_PULSE_CYC)); // see RULE11
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n || !tif.run) begin
      tck_q    <= 32'h0000_0000;
      tif.tick <= 1'b0;
    end else begin
      tif.tick <= (tck_q == 32'(TICK_CYC - 1));
      tck_q    <= (tck_q == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tck_q + 32'h0000_0001;
    end
  end
endmodule : pmc_pulse_timer
`default_nettype wire

// ---- verilog/pmc_wake_reset.sv ----
// internal reset generator used on hardware power-down release and soft wake
`default_nettype none
module pmc_wake_reset
  import pmc_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // request and reset output
  input  wire logic start,
  output logic      int_rst
);
  logic [4:0] cnt_q; // remaining reset cycles
  // ----------------------------------------------------------------
  // hold int_rst for a fixed count after each start
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= 5'(PMC_WAKE_RST_CYC);
    end else if (start) begin
      cnt_q <= 5'(PMC_WAKE_RST_CYC);
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
  assign int_rst = (cnt_q != 5'h00);
endmodule : pmc_wake_reset
`default_nettype wire

// ---- verilog/pmc_power_ctrl.sv ----
// top of the power mode controller: apb registers, mode decode, energy detect, wake
//
// The register offsets and the APB slave port were chosen for this implementation.
`default_nettype none
// Overview of operation
// RULE1 - power-down pin low powers chip off, reset on release
// RULE2 - mode field 00 normal 01 energy 10 soft 11 save
// RULE3 - port phy off by control bit or phy bit
// RULE4 - after reset mode normal, everything on
// RULE5 - normal or saving mode lets host change mode
// RULE6 - saving needs autoneg, no cable, field 11
// RULE7 - saving keeps tx, receive idle until activity
// RULE8 - writing 01 enters energy detect, two states
// RULE9 - no energy past go-sleep time enters low power
// RULE10 - energy returns low power to normal state
// RULE11 - energy mode sends 120 ns pulse each second
// RULE12 - writing 10 stops plls, phys and macs
// RULE13 - any host access wakes soft power-down with reset
// RULE14 - host repeats writes after wake reset
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int NPORTS     = PMC_NPORTS,
  parameter int PERIOD_CYC = PMC_PERIOD_CYC,
  parameter int TICK_CYC   = PMC_TICK_CYC
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // power-down pin and phy status
  input  wire logic              chip_power_down_n,
  input  wire logic [NPORTS-1:0] phy_ctrl_pd,
  input  wire logic              autoneg_en,
  input  wire logic [NPORTS-1:0] cable_energy,
  input  wire logic [NPORTS-1:0] link_up,
  // power controls
  output logic                   pll_en,
  output logic                   mac_en,
  output logic                   host_en,
  output logic      [NPORTS-1:0] phy_tx_en,
  output logic      [NPORTS-1:0] phy_rx_en,
  output logic                   ed_rx_en,
  output logic                   link_pulse,
  output logic                   chip_reset
);
  // elaboration check: the per-port enables and status read assume at most eight ports
  if (NPORTS < 1 || NPORTS > 8) begin : g_bad_nports
    $error("pmc: NPORTS must be 1..8");
  end
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  pmc_mode_type      mode_q;     // global mode field
  logic [7:0]        sleep_q;    // go-sleep time in ticks
  logic [NPORTS-1:0] portpd_q;   // per-port power-down bits
  logic              low_pwr_q;  // energy detect low power state
  logic [7:0]        idle_q;     // ticks without energy
  logic              pd_q;       // pin held power-down state
  logic              int_rst;    // internal reset from generator
  logic              wake_start; // restart of the internal reset
  logic              ready_q;    // apb access phase answer
  logic              wr_ok;      // write strobe
  logic              any_energy; // energy on any cable
  logic              save_ok;    // power saving conditions hold
  logic              srst_n;     // combined register reset
  pmc_tick_if        tif ();
  // ----------------------------------------------------------------
  // hardware power-down and wake reset
  // ----------------------------------------------------------------
  // pin release and soft wake both restart the internal reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pd_q <= 1'b0;
    end else begin
      pd_q <= !chip_power_down_n; // see RULE1
    end
  end
  // release edge of the pin, or any access while soft powered down
  assign wake_start = (pd_q && chip_power_down_n) ||
                      (mode_q == PMC_SOFT_PD && psel && !penable); // see RULE13
  pmc_wake_reset u_wake (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (wake_start),
    .int_rst (int_rst)
  );
  assign srst_n = rst_n && !int_rst && !pd_q;
  // ----------------------------------------------------------------
  // apb slave: no wait state, access completes on second cycle
  // ----------------------------------------------------------------
  assign wr_ok = psel && penable && ready_q && pwrite;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= psel && !ready_q; // single-cycle pulse per access
    end
  end
  assign pready = ready_q;
  // bus stays answerable during the wake reset so a wake access finishes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !ready_q && !pwrite) begin
      pslverr <= 1'b0;
      unique case (paddr)
        PMC_MODE_OFS:   prdata <= 32'(mode_q) << PMC_MODE_LSB;
        PMC_SLEEP_OFS:  prdata <= {24'h00_0000, sleep_q};
        PMC_PORTPD_OFS: prdata <= 32'(portpd_q);
        PMC_STATUS_OFS: prdata <= {29'h0000_0000, save_ok, low_pwr_q, pll_en};
        default: begin
          prdata  <= 32'h0000_0000;
          pslverr <= 1'b1; // unmapped address
        end
      endcase
    end else if (psel && !ready_q) begin
      prdata  <= 32'h0000_0000;
      pslverr <= !(paddr inside {PMC_MODE_OFS, PMC_SLEEP_OFS, PMC_PORTPD_OFS});
    end
  end
  // ----------------------------------------------------------------
  // mode register; a wake access is discarded by the reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!srst_n) begin
      mode_q <= PMC_NORMAL; // see RULE4
    end else if (wr_ok && paddr == PMC_MODE_OFS && mode_q != PMC_SOFT_PD) begin
      // normal and saving leave to any mode, energy detect too
      mode_q <= pmc_mode_type'(pwdata[PMC_MODE_MSB:PMC_MODE_LSB]); // see RULE5
    end
  end
  always_ff @(posedge clock) begin
    if (!srst_n) begin
      sleep_q  <= PMC_SLEEP_RST;
      portpd_q <= '0;
    end else if (wr_ok && paddr == PMC_SLEEP_OFS) begin
      sleep_q <= pwdata[7:0];
    end else if (wr_ok && paddr == PMC_PORTPD_OFS) begin
      portpd_q <= pwdata[NPORTS-1:0];
    end
  end
  // ----------------------------------------------------------------
  // energy detect sub state
  // ----------------------------------------------------------------
  assign any_energy = |cable_energy;
  assign tif.run    = (mode_q == PMC_ENERGY) && srst_n; // see RULE8
  pmc_pulse_timer #(
    .PERIOD_CYC (PERIOD_CYC),
    .TICK_CYC   (TICK_CYC)
  ) u_timer (
    .clock (clock),
    .rst_n (rst_n),
    .tif   (tif)
  );
  always_ff @(posedge clock) begin
    if (!srst_n || mode_q != PMC_ENERGY) begin
      low_pwr_q <= 1'b0;
      idle_q    <= 8'h00;
    end else if (any_energy) begin
      low_pwr_q <= 1'b0; // see RULE10
      idle_q    <= 8'h00;
    end else if (tif.tick) begin
      if (idle_q >= sleep_q) begin
        low_pwr_q <= 1'b1; // see RULE9
      end else begin
        idle_q <= idle_q + 8'h01;
      end
    end
  end
  // ----------------------------------------------------------------
  // power saving qualifier: autoneg on and no cable
  // ----------------------------------------------------------------
  assign save_ok = (mode_q == PMC_PWR_SAVE) && autoneg_en && !(|link_up); // see RULE6
  // ----------------------------------------------------------------
  // decoded power controls, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pll_en     <= 1'b1;
      mac_en     <= 1'b1;
      host_en    <= 1'b1;
      phy_tx_en  <= '1;
      phy_rx_en  <= '1;
      ed_rx_en   <= 1'b0;
      link_pulse <= 1'b0;
      chip_reset <= 1'b0;
    end else begin
      chip_reset <= int_rst || pd_q;
      link_pulse <= tif.pulse && !pd_q; // see RULE11
      ed_rx_en   <= !pd_q && (mode_q == PMC_ENERGY);
      if (pd_q) begin
        pll_en    <= 1'b0; // see RULE1
        mac_en    <= 1'b0;
        host_en   <= 1'b0;
        phy_tx_en <= '0;
        phy_rx_en <= '0;
      end else begin
        unique case (mode_q) // see RULE2
          PMC_NORMAL: begin
            pll_en    <= 1'b1;
            mac_en    <= 1'b1;
            host_en   <= 1'b1;
            phy_tx_en <= ~(portpd_q | phy_ctrl_pd); // see RULE3
            phy_rx_en <= ~(portpd_q | phy_ctrl_pd);
          end
          PMC_PWR_SAVE: begin
            pll_en    <= 1'b1;
            mac_en    <= 1'b1;
            host_en   <= 1'b1;
            phy_tx_en <= ~(portpd_q | phy_ctrl_pd); // see RULE7
            // receive block off only while idle; activity powers it up
            phy_rx_en <= ~(portpd_q | phy_ctrl_pd) &
                         ((save_ok ? cable_energy : '1) | link_up);
          end
          PMC_ENERGY: begin
            pll_en    <= !low_pwr_q;
            mac_en    <= !low_pwr_q;
            host_en   <= !low_pwr_q;
            phy_tx_en <= low_pwr_q ? '0 : ~(portpd_q | phy_ctrl_pd);
            phy_rx_en <= low_pwr_q ? '0 : ~(portpd_q | phy_ctrl_pd);
          end
          PMC_SOFT_PD: begin
            pll_en    <= 1'b0; // see RULE12
            mac_en    <= 1'b0;
            host_en   <= 1'b0;
            phy_tx_en <= '0;
            phy_rx_en <= '0;
          end
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // length of the running link pulse; a counter keeps the width check off a long repetition
  logic [7:0] pw_q;
  always_ff @(posedge clock) begin
    if (!rst_n || !tif.pulse) begin
      pw_q <= 8'h00;
    end else if (pw_q != 8'hff) begin
      pw_q <= pw_q + 8'h01; // saturates so a stuck pulse cannot wrap back to a legal width
    end
  end
  a_pin_powers_down: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
    !chip_power_down_n |-> ##2 !pll_en && !mac_en) else $error("pin low did not power down");
  a_pin_release_rst: assert property (@(posedge clock) disable iff (!rst_n) // see RULE1
    pd_q && chip_power_down_n |=> int_rst) else $error("no internal reset on release");
  a_soft_decode: assert property (@(posedge clock) disable iff (!rst_n) // see RULE12
    mode_q == PMC_SOFT_PD && !pd_q && !int_rst ##1 mode_q == PMC_SOFT_PD |->
    !pll_en && !mac_en && phy_tx_en == '0 && phy_rx_en == '0)
    else $error("soft power-down left clocks on");
  a_wake_to_normal: assert property (@(posedge clock) disable iff (!rst_n) // see RULE13
    mode_q == PMC_SOFT_PD && psel && !penable |=> ##1 mode_q == PMC_NORMAL)
    else $error("access did not wake");
  a_mode_write: assert property (@(posedge clock) disable iff (!srst_n) // see RULE5
    wr_ok && paddr == PMC_MODE_OFS && mode_q == PMC_NORMAL |=>
    mode_q == pmc_mode_type'($past(pwdata[PMC_MODE_MSB:PMC_MODE_LSB])))
    else $error("mode write lost");
  a_energy_wake: assert property (@(posedge clock) disable iff (!rst_n) // see RULE10
    low_pwr_q && any_energy && mode_q == PMC_ENERGY |=> !low_pwr_q)
    else $error("no wake on energy");
  a_sleep_on_idle: assert property (@(posedge clock) disable iff (!rst_n) // see RULE9
    low_pwr_q && $stable(mode_q) && mode_q == PMC_ENERGY && !any_energy |=> low_pwr_q)
    else $error("low power left without energy");
  a_normal_on: assert property (@(posedge clock) disable iff (!rst_n) // see RULE4
    mode_q == PMC_NORMAL && !pd_q ##1 !pd_q |-> pll_en && mac_en && host_en)
    else $error("normal mode not fully on");
  a_pulse_width: assert property (@(posedge clock) disable iff (!rst_n) // see RULE11
    $fell(tif.pulse) && $past(tif.run) |-> pw_q == 8'(PMC_PULSE_CYC))
    else $error("bad pulse width");
  a_port_pd: assert property (@(posedge clock) disable iff (!rst_n) // see RULE3
    mode_q == PMC_NORMAL && !pd_q && portpd_q[0] |=> !phy_tx_en[0]) else $error("port not down");
  a_save_on: assert property (@(posedge clock) disable iff (!rst_n) // see RULE6
    mode_q == PMC_PWR_SAVE && !pd_q ##1 !pd_q |-> pll_en && mac_en && host_en)
    else $error("power saving turned clocks off");
  a_save_tx_on: assert property (@(posedge clock) disable iff (!rst_n) // see RULE7
    mode_q == PMC_PWR_SAVE && !pd_q && portpd_q == '0 && phy_ctrl_pd == '0 |=> phy_tx_en == '1)
    else $error("power saving stopped transmit");
  a_low_pwr_off: assert property (@(posedge clock) disable iff (!rst_n) // see RULE9
    mode_q == PMC_ENERGY && low_pwr_q && !pd_q |=> !pll_en && phy_rx_en == '0 && ed_rx_en)
    else $error("low power state left circuits on");
  a_sleep_entry: assert property (@(posedge clock) disable iff (!rst_n) // see RULE9
    srst_n && mode_q == PMC_ENERGY && tif.tick && !any_energy && idle_q >= sleep_q |=> low_pwr_q)
    else $error("idle cable did not enter low power");
  a_soft_wake_rst: assert property (@(posedge clock) disable iff (!rst_n) // see RULE13
    mode_q == PMC_SOFT_PD && psel && !penable |=> int_rst) else $error("wake gave no reset");
  c_enter_energy: cover property (@(posedge clock) disable iff (!rst_n) $rose(low_pwr_q));
  c_soft_wake:    cover property (@(posedge clock) disable iff (!rst_n)
    wake_start && mode_q == PMC_SOFT_PD);
  c_save_mode:    cover property (@(posedge clock) disable iff (!rst_n) save_ok);
  c_pulse_done:   cover property (@(posedge clock) disable iff (!rst_n) $fell(tif.pulse));
  c_pin_down:     cover property (@(posedge clock) disable iff (!rst_n) $rose(pd_q));
endmodule : pmc_power_ctrl
`default_nettype wire

// ---- verification/tb_pmc_power_ctrl.sv ----
// self-checking testbench for the power mode controller
`default_nettype none
// compares two values, counts the check and reports a mismatch at once
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module tb_pmc_power_ctrl
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // settings: short counts keep the run brief
  // ----------------------------------------------------------------
  localparam int PER   = 200;  // pulse period in cycles
  localparam int TCK   = 10;   // go-sleep tick in cycles
  localparam int LIMIT = 6000; // hang ceiling, far above the expected run
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic              clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              chip_power_down_n, autoneg_en;
  logic [PMC_NPORTS-1:0] phy_ctrl_pd, cable_energy, link_up, phy_tx_en, phy_rx_en;
  logic              pll_en, mac_en, host_en, ed_rx_en, link_pulse, chip_reset;
  int                n_errors, n_tests, cyc, i, w;
  logic [4:0]        pa, pb;  // random port power-down patterns
  logic [31:0]       seed_v;  // result of the seeding call, unused
  // expected bus answer: mask, data, error flag, error check enable
  typedef struct packed { logic [31:0] m; logic [31:0] d; logic e; logic ce; } pmc_tb_exp_type;
  pmc_tb_exp_type    exp_q[$];
  pmc_tb_exp_type    exp_cur;
  // ----------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------
  pmc_power_ctrl #(.NPORTS(PMC_NPORTS), .PERIOD_CYC(PER), .TICK_CYC(TCK)) pmc_power_ctrl_inst (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_power_down_n(chip_power_down_n), .phy_ctrl_pd(phy_ctrl_pd),
    .autoneg_en(autoneg_en), .cable_energy(cable_energy), .link_up(link_up),
    .pll_en(pll_en), .mac_en(mac_en), .host_en(host_en), .phy_tx_en(phy_tx_en),
    .phy_rx_en(phy_rx_en), .ed_rx_en(ed_rx_en), .link_pulse(link_pulse),
    .chip_reset(chip_reset));
  // ----------------------------------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------------------------------
  initial clock = 1'b0;
  always #5 clock = ~clock;
  // verdict in one place, reached by the main sequence or the watchdog
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      $display("timeout after %0d cycles", cyc);
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // bus monitor: pops the oldest note when an access completes
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("wrong value at %0t: got %h expected %h", $time, prdata, 32'h0000_0000);
      end else begin
        exp_cur = exp_q.pop_front();
        if (exp_cur.ce) `CHK(pslverr, exp_cur.e)
        `CHK(prdata & exp_cur.m, exp_cur.d & exp_cur.m)
      end
    end
  end
  // ----------------------------------------------------------------
  // bus tasks: entered just after a rising edge
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] m, input logic [31:0] d, input logic e,
                     input logic ce);
    exp_q.push_back('{m: m, d: d, e: e, ce: ce});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clock);
    penable <= 1'b1;
    // request held until pready is seen high at an edge; only the watchdog ends a hang
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never lands in the same step
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d);
    apb(1'b0, a, 32'h0000_0000, m, d, 1'b0, 1'b1);
  endtask : rd
  // outputs follow a register change one cycle later; allow margin
  task automatic settle;
    repeat (3) @(posedge clock);
  endtask : settle
  // internal reset: wait for it to start, then for it to end
  task automatic wait_int_rst;
    for (i = 0; i < 10 && chip_reset !== 1'b1; i++) @(posedge clock);
    for (i = 0; i < 40 && chip_reset !== 1'b0; i++) @(posedge clock);
    `CHK(chip_reset, 1'b0)
  endtask : wait_int_rst
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_errors = 0; n_tests = 0; cyc = 0;
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000;
    chip_power_down_n = 1'b1; phy_ctrl_pd = 5'h00; autoneg_en = 1'b1;
    cable_energy = 5'h1f; link_up = 5'h1f;
    seed_v = $urandom(94480);
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    wait_int_rst();
    // defaults after reset
    `CHK(pll_en, 1'b1)
    `CHK(mac_en & host_en, 1'b1)
    `CHK(phy_tx_en & phy_rx_en, 5'h1f)
    `CHK(ed_rx_en, 1'b0)
    rd(PMC_MODE_OFS, 32'h0000_0018, 32'h0000_0000);
    rd(PMC_SLEEP_OFS, 32'h0000_00ff, {24'h0, PMC_SLEEP_RST});
    rd(PMC_STATUS_OFS, 32'h0000_0001, 32'h0000_0001);
    apb(1'b0, 8'h10, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000, 1'b1, 1'b1);
    $display("test reset_defaults done");
    // per-port power-down from either source, random patterns
    for (int k = 0; k < 4; k++) begin
      pa = 5'($urandom);
      pb = 5'($urandom);
      phy_ctrl_pd <= pb;
      wr(PMC_PORTPD_OFS, {27'h0, pa});
      rd(PMC_PORTPD_OFS, 32'h0000_001f, {27'h0, pa});
      settle();
      `CHK(phy_tx_en, ~(pa | pb))
      `CHK(phy_rx_en, ~(pa | pb))
    end
    phy_ctrl_pd <= 5'h00;
    wr(PMC_PORTPD_OFS, 32'h0000_0000);
    $display("test port_power_down done");
    // power saving: autoneg on, no cable, field 11
    cable_energy <= 5'h00;
    link_up <= 5'h00;
    wr(PMC_SLEEP_OFS, 32'h0000_0003);
    wr(PMC_MODE_OFS, 32'h0000_0018);
    settle();
    `CHK(pll_en & mac_en & host_en, 1'b1)
    `CHK(phy_tx_en, 5'h1f)
    `CHK(phy_rx_en, 5'h00)
    rd(PMC_STATUS_OFS, 32'h0000_0005, 32'h0000_0005);
    cable_energy <= 5'h05;
    settle();
    `CHK(phy_rx_en, 5'h05)
    // without auto-negotiation the saving qualifier drops and receive stays on
    autoneg_en <= 1'b0;
    settle();
    `CHK(phy_rx_en, 5'h1f)
    rd(PMC_STATUS_OFS, 32'h0000_0004, 32'h0000_0000);
    autoneg_en <= 1'b1;
    $display("test power_saving done");
    // energy detect entered straight from power saving
    cable_energy <= 5'h1f;
    wr(PMC_MODE_OFS, 32'h0000_0008);
    settle();
    `CHK(ed_rx_en, 1'b1)
    rd(PMC_MODE_OFS, 32'h0000_0018, 32'h0000_0008);
    // line pulse: skip a pulse already running, then measure width and spacing
    for (i = 0; i < 50 && link_pulse === 1'b1; i++) @(posedge clock);
    for (i = 0; i < 2 * PER && link_pulse !== 1'b1; i++) @(posedge clock);
    w = 0;
    while (link_pulse === 1'b1 && w < 50) begin
      w++;
      @(posedge clock);
    end
    `CHK(w, PMC_PULSE_CYC)
    while (link_pulse !== 1'b1 && w < 2 * PER) begin
      w++;
      @(posedge clock);
    end
    `CHK(w, PER)
    // idle cable: not asleep after two ticks, asleep well past three
    cable_energy <= 5'h00;
    repeat (2 * TCK) @(posedge clock);
    rd(PMC_STATUS_OFS, 32'h0000_0002, 32'h0000_0000);
    repeat (6 * TCK) @(posedge clock);
    rd(PMC_STATUS_OFS, 32'h0000_0002, 32'h0000_0002);
    `CHK(phy_rx_en, 5'h00)
    `CHK(ed_rx_en, 1'b1)
    cable_energy <= 5'h1f;
    settle();
    rd(PMC_STATUS_OFS, 32'h0000_0002, 32'h0000_0000);
    $display("test energy_detect done");
    // soft power-down, then a dummy access wakes with defaults
    wr(PMC_MODE_OFS, 32'h0000_0010);
    settle();
    `CHK(pll_en | mac_en, 1'b0)
    `CHK(phy_tx_en | phy_rx_en, 5'h00)
    // the waking access is a write, so its loss to the reset can be seen
    apb(1'b1, PMC_SLEEP_OFS, 32'h0000_0066, 32'h0000_0000, 32'h0000_0000, 1'b0, 1'b0);
    wait_int_rst();
    rd(PMC_MODE_OFS, 32'h0000_0018, 32'h0000_0000);
    rd(PMC_SLEEP_OFS, 32'h0000_00ff, {24'h0, PMC_SLEEP_RST});
    wr(PMC_SLEEP_OFS, 32'h0000_0066);
    rd(PMC_SLEEP_OFS, 32'h0000_00ff, 32'h0000_0066);
    `CHK(pll_en, 1'b1)
    $display("test soft_power_down done");
    // hardware power-down pin, then internal reset on release
    wr(PMC_SLEEP_OFS, 32'h0000_0055);
    chip_power_down_n <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK(pll_en | mac_en | host_en, 1'b0)
    `CHK(chip_reset, 1'b1)
    chip_power_down_n <= 1'b1;
    wait_int_rst();
    rd(PMC_SLEEP_OFS, 32'h0000_00ff, {24'h0, PMC_SLEEP_RST});
    `CHK(pll_en, 1'b1)
    $display("test pin_power_down done");
    repeat (3) @(posedge clock);
    `CHK(exp_q.size(), 0)
    wrap_up();
  end
endmodule : tb_pmc_power_ctrl
`default_nettype wire
